//--- crpm_pkg.sv
// Constants and carrier types for the cartridge ROM page mapper.
// Assumes a single 10 MHz system clock and a synchronous reset.
package crpm_pkg;

  // Clock period of the system clock in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 100;

  // I/O port decode: upper address byte of each port.
  localparam logic [7:0] HIGH_BANK_PORT_HI = 8'hDF;
  localparam logic [7:0] GATE_PORT_HI = 8'h7F;

  // Data-bit positions of the gate register family.
  localparam int unsigned SEL_HI_BIT = 7;
  localparam int unsigned SEL_LO_BIT = 6;
  localparam int unsigned SECONDARY_BIT = 5;
  localparam int unsigned LOWMAP_HI_BIT = 4;
  localparam int unsigned LOWMAP_LO_BIT = 3;
  localparam int unsigned GATE_UPPER_OFF_BIT = 3;
  localparam int unsigned GATE_LOWER_OFF_BIT = 2;

  // High-bank translation constants.
  localparam logic [7:0] DIRECT_PAGE_LIMIT = 8'h80;
  localparam logic [7:0] DISK_CODE_ALT = 8'h07;
  localparam logic [7:0] DISK_CODE_DEF = 8'h00;
  localparam logic [4:0] INTERP_PAGE = 5'h01;
  localparam logic [4:0] DISK_PAGE = 5'h03;

  // Reset values.
  localparam logic [7:0] HIGH_BANK_RESET = 8'h00;
  localparam logic [1:0] LOWMAP_RESET = 2'h0;
  localparam logic [2:0] LOW_PAGE_RESET = 3'h0;
  localparam logic [1:0] GATE_OFF_RESET = 2'h0;

  // Unlock sequence length.
  localparam int unsigned UNLOCK_LEN = 4;

  // CPU window numbers (address bits 15:14).
  localparam logic [1:0] WIN_0000 = 2'h0;
  localparam logic [1:0] WIN_4000 = 2'h1;
  localparam logic [1:0] WIN_8000 = 2'h2;
  localparam logic [1:0] WIN_C000 = 2'h3;

  // Low bank placement codes.
  typedef enum logic [1:0] {
    CRPM_LOW_AT_0000,
    CRPM_LOW_AT_4000,
    CRPM_LOW_AT_8000,
    CRPM_LOW_AT_0000_REGS
  } crpm_lowmap_e;

  // One CPU cycle as seen by the mapper.
  typedef struct packed {
    logic io_wr;
    logic mem_rd;
    logic mem_wr;
    logic [15:0] addr;
    logic [7:0] data;
  } crpm_cycle_s;

  // Memory steering result of the mapper.
  typedef struct packed {
    logic rom_sel;
    logic ram_wr;
    logic regpage_sel;
    logic [4:0] rom_page;
  } crpm_route_s;

endpackage

//--- crpm_unlock.sv
// Feature lock: watches I/O writes for the unlock byte sequence.
// Assumes one I/O write pulse per cycle from the CPU interface.
`timescale 1ns/10ps
module crpm_unlock #(
  parameter logic [31:0] SEQ = 32'hA5_5A_C3_3C
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic IO_WR,
  input wire logic [7:0] IO_DATA,
  output logic OPEN
);

  // Number of bytes matched so far.
  logic [2:0] idx_q;
  // Lock state, closed after reset.
  logic open_q;

  // Byte expected next; the list runs from the top byte down.
  function automatic logic [7:0] seq_byte(input logic [2:0] i);
    seq_byte = SEQ[8'(31 - 8 * int'(i)) -: 8];
  endfunction

  // Match progress: a wrong byte restarts the match, and counts as the first byte if it equals it.
  always_ff @(posedge CLK) begin
    if (RST) begin
      idx_q <= 3'h0;
    end else if (IO_WR && !open_q) begin
      if (IO_DATA == seq_byte(idx_q)) begin
        idx_q <= idx_q + 3'h1;
      end else if (IO_DATA == seq_byte(3'h0)) begin
        idx_q <= 3'h1;
      end else begin
        idx_q <= 3'h0;
      end
    end
  end

  // The lock opens once the last byte of the list has matched.
  always_ff @(posedge CLK) begin
    if (RST) begin
      open_q <= 1'b0;
    end else if (IO_WR && !open_q && IO_DATA == seq_byte(idx_q) &&
                 idx_q == 3'(crpm_pkg::UNLOCK_LEN - 1)) begin
      open_q <= 1'b1;
    end
  end

  assign OPEN = open_q;

endmodule

//--- crpm_mapper.sv
// Cartridge ROM page mapper: high-bank port, secondary low-bank map,
// ROM gating, write-through steering and the register page select.
// Assumes synchronous CPU strobes, one cycle per access, on CLK.
`timescale 1ns/10ps
module crpm_mapper #(
  parameter logic [31:0] UNLOCK_SEQ = 32'hA5_5A_C3_3C
) (
  input wire logic CLK,
  input wire logic RST,
  input wire crpm_pkg::crpm_cycle_s CPU,
  input wire logic DISK_CODE_ALT_SEL,
  input wire logic EXT_ROM_INHIBIT,
  input wire logic EXP_ROM_ACTIVE,
  input wire logic [4:0] EXP_ROM_PAGE,
  output crpm_pkg::crpm_route_s ROUTE,
  output logic [4:0] CART_ADDR_HI,
  output logic FEATURES_OPEN,
  output logic [1:0] GATE_OFF
);

  // Last value written to the high-bank port.
  logic [7:0] high_sel_q;
  // Low bank placement and page from the secondary register.
  logic [1:0] lowmap_q;
  logic [2:0] low_page_q;
  // ROM disable bits of the gate register: {upper, lower}.
  logic [1:0] gate_off_q;
  // Lock state from the sequence detector.
  logic lock_open;
  // Decoded writes, each high for the one cycle of its I/O strobe.
  logic hb_wr; // Write to the high-bank port.
  logic gate_fam_wr; // Write to the gate register family.
  logic rmr_wr; // Write that loads the secondary register.
  logic gate_wr; // Write that loads the gate bits.
  // Combinational steering for the cycle on the bus now.
  logic [1:0] win; // CPU window, address bits 15:14.
  logic low_hit; // Low bank ROM answers this window.
  logic high_hit; // High bank ROM answers this window.
  logic regs_hit; // Register page answers this window.
  logic rom_hit; // Cartridge ROM finally takes the cycle.
  logic [4:0] high_page; // Physical page of the high bank.
  logic [4:0] page; // Physical page shown for this cycle.
  logic disk_sel; // High bank currently shows the disk page.
  logic rom_live; // No expansion ROM claims this page number.
  // Next value of the registered steering outputs.
  crpm_pkg::crpm_route_s route_d;

  // Translate a high-bank port value into a physical page.
  function automatic logic [4:0] high_xlate(input logic [7:0] v,
                                            input logic alt);
    logic [7:0] code;
    code = alt ? crpm_pkg::DISK_CODE_ALT : crpm_pkg::DISK_CODE_DEF;
    if (v >= crpm_pkg::DIRECT_PAGE_LIMIT) begin
      high_xlate = v[4:0];
    end else if (v == code) begin
      high_xlate = crpm_pkg::DISK_PAGE;
    end else begin
      high_xlate = crpm_pkg::INTERP_PAGE;
    end
  endfunction

  // The sequence detector lives in its own module to keep the map clean.
  crpm_unlock #(
    .SEQ(UNLOCK_SEQ)
  ) u_unlock (
    .CLK(CLK),
    .RST(RST),
    .IO_WR(CPU.io_wr),
    .IO_DATA(CPU.data),
    .OPEN(lock_open)
  );

  // Port decode uses only the upper address byte, as the bus does.
  assign hb_wr = CPU.io_wr && CPU.addr[15:8] == crpm_pkg::HIGH_BANK_PORT_HI;
  assign gate_fam_wr = CPU.io_wr &&
                       CPU.addr[15:8] == crpm_pkg::GATE_PORT_HI &&
                       CPU.data[crpm_pkg::SEL_HI_BIT] &&
                       !CPU.data[crpm_pkg::SEL_LO_BIT];
  // Bit 5 only reaches the secondary register while unlocked.
  assign rmr_wr = gate_fam_wr && CPU.data[crpm_pkg::SECONDARY_BIT] &&
                  lock_open;
  assign gate_wr = gate_fam_wr && !rmr_wr;

  // High-bank port store; holds the raw byte so the disk code can change.
  always_ff @(posedge CLK) begin
    if (RST) begin
      high_sel_q <= crpm_pkg::HIGH_BANK_RESET;
    end else if (hb_wr) begin
      high_sel_q <= CPU.data;
    end
  end

  // Secondary register: placement and low page.
  always_ff @(posedge CLK) begin
    if (RST) begin
      lowmap_q <= crpm_pkg::LOWMAP_RESET;
      low_page_q <= crpm_pkg::LOW_PAGE_RESET;
    end else if (rmr_wr) begin
      lowmap_q <= CPU.data[crpm_pkg::LOWMAP_HI_BIT:
                           crpm_pkg::LOWMAP_LO_BIT];
      low_page_q <= CPU.data[2:0];
    end
  end

  // Gate register ROM disable bits; other bits belong to video logic.
  always_ff @(posedge CLK) begin
    if (RST) begin
      gate_off_q <= crpm_pkg::GATE_OFF_RESET;
    end else if (gate_wr) begin
      gate_off_q <= {CPU.data[crpm_pkg::GATE_UPPER_OFF_BIT],
                     CPU.data[crpm_pkg::GATE_LOWER_OFF_BIT]};
    end
  end

  // Window decode; the two banks are decoded separately.
  always_comb begin
    win = CPU.addr[15:14];
    high_page = high_xlate(high_sel_q, DISK_CODE_ALT_SEL);
    disk_sel = high_page == crpm_pkg::DISK_PAGE &&
               high_sel_q < crpm_pkg::DIRECT_PAGE_LIMIT;
    regs_hit = lowmap_q == 2'(crpm_pkg::CRPM_LOW_AT_0000_REGS) &&
               win == crpm_pkg::WIN_4000;
    // The placement code decides which window the low bank answers.
    case (crpm_pkg::crpm_lowmap_e'(lowmap_q))
      crpm_pkg::CRPM_LOW_AT_0000: low_hit = win == crpm_pkg::WIN_0000;
      crpm_pkg::CRPM_LOW_AT_4000: low_hit = win == crpm_pkg::WIN_4000;
      crpm_pkg::CRPM_LOW_AT_8000: low_hit = win == crpm_pkg::WIN_8000;
      crpm_pkg::CRPM_LOW_AT_0000_REGS: low_hit = win == crpm_pkg::WIN_0000;
      default: low_hit = 1'b0;
    endcase
    high_hit = win == crpm_pkg::WIN_C000;
    // Disables act wherever the bank sits; inhibit covers the disk page.
    low_hit = low_hit && !gate_off_q[0] && !EXT_ROM_INHIBIT;
    high_hit = high_hit && !gate_off_q[1] && !EXT_ROM_INHIBIT;
    page = high_hit ? high_page : {2'h0, low_page_q};
    // Expansion ROM on the same page number takes the cycle.
    rom_live = !(EXP_ROM_ACTIVE && EXP_ROM_PAGE == page);
    rom_hit = (low_hit || high_hit) && rom_live;
    // Only reads fetch from ROM; writes go on to RAM below.
    route_d.rom_sel = rom_hit && CPU.mem_rd;
    // The register page answers reads and writes alike.
    route_d.regpage_sel = regs_hit && (CPU.mem_rd || CPU.mem_wr);
    // Writes into ROM fall through to RAM; register page swallows them.
    route_d.ram_wr = CPU.mem_wr && !regs_hit;
    route_d.rom_page = page;
  end

  // Steering and cartridge address outputs are registered.
  always_ff @(posedge CLK) begin
    if (RST) begin
      // Nothing is steered anywhere while reset is held.
      ROUTE <= '0;
      CART_ADDR_HI <= 5'h00;
    end else begin
      ROUTE <= route_d;
      CART_ADDR_HI <= page;
    end
  end

  // Status outputs come straight from their flip-flops.
  assign FEATURES_OPEN = lock_open;
  assign GATE_OFF = gate_off_q;

  // A direct port value keeps its low five bits in the store.
  property p_high_page;
    @(posedge CLK) disable iff (RST)
      (hb_wr && CPU.data >= 8'h80) |=>
        high_sel_q[4:0] == $past(CPU.data[4:0]);
  endproperty
  a_high_page: assert property (p_high_page) else $error("high page");

  // Every port write replaces the whole stored byte.
  property p_hb_store;
    @(posedge CLK) disable iff (RST)
      hb_wr |=> high_sel_q == $past(CPU.data);
  endproperty
  a_hb_store: assert property (p_hb_store) else $error("port store");

  // A direct value drives its low five bits onto the address lines.
  property p_direct;
    @(posedge CLK) disable iff (RST)
      (high_sel_q >= 8'h80 && high_hit) |=>
        CART_ADDR_HI == $past(high_sel_q[4:0]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct page");

  // Below 128 and not the disk code, the interpreter page shows.
  property p_interp;
    @(posedge CLK) disable iff (RST)
      (high_sel_q < 8'h80 && high_sel_q != 8'h00 && high_sel_q != 8'h07 &&
       win == 2'h3 && !gate_off_q[1] && !EXT_ROM_INHIBIT && !EXP_ROM_ACTIVE)
      |=> CART_ADDR_HI == 5'h01;
  endproperty
  a_interp: assert property (p_interp) else $error("interp page");

  // The disk code shows the disk page unless the high bank is off.
  property p_disk;
    @(posedge CLK) disable iff (RST)
      (win == 2'h3 && high_sel_q == (DISK_CODE_ALT_SEL ? 8'h07 : 8'h00) &&
       !gate_off_q[1] && !EXT_ROM_INHIBIT)
      |=> CART_ADDR_HI == 5'h03;
  endproperty
  a_disk: assert property (p_disk) else $error("disk page");

  // A secondary write takes placement and page from the data.
  property p_rmr_store;
    @(posedge CLK) disable iff (RST)
      rmr_wr |=> lowmap_q == $past(CPU.data[4:3]) &&
        low_page_q == $past(CPU.data[2:0]);
  endproperty
  a_rmr_store: assert property (p_rmr_store) else $error("map store");

  // The low bank shows its logical page as the physical page.
  property p_low_page;
    @(posedge CLK) disable iff (RST)
      low_hit |=> CART_ADDR_HI == {2'h0, $past(low_page_q)};
  endproperty
  a_low_page: assert property (p_low_page) else $error("low page");

  // While locked the secondary register cannot move.
  property p_locked;
    @(posedge CLK) disable iff (RST)
      !lock_open |=> $stable(lowmap_q) && $stable(low_page_q);
  endproperty
  a_locked: assert property (p_locked) else $error("lock leak");

  // While locked a bit 5 write loads the gate bits instead.
  property p_locked_gate;
    @(posedge CLK) disable iff (RST)
      (gate_fam_wr && !lock_open) |=> gate_off_q ==
        {$past(CPU.data[3]), $past(CPU.data[2])};
  endproperty
  a_locked_gate: assert property (p_locked_gate) else $error("gate");

  // An expansion ROM on the same page number takes the cycle.
  property p_exp_prio;
    @(posedge CLK) disable iff (RST)
      (EXP_ROM_ACTIVE && EXP_ROM_PAGE == page) |=> !ROUTE.rom_sel;
  endproperty
  a_exp_prio: assert property (p_exp_prio) else $error("exp prio");

  // The lower gate bit keeps the low bank off wherever it sits.
  property p_gate_low;
    @(posedge CLK) disable iff (RST)
      (gate_off_q[0] && win != crpm_pkg::WIN_C000) |=> !ROUTE.rom_sel;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate low");

  // Register page writes are swallowed, never passed to RAM.
  property p_regs_nowr;
    @(posedge CLK) disable iff (RST)
      (CPU.mem_wr && regs_hit) |=> !ROUTE.ram_wr && ROUTE.regpage_sel;
  endproperty
  a_regs_nowr: assert property (p_regs_nowr) else $error("reg wr");

  // Any other write falls through to RAM, ROM or not.
  property p_wthru;
    @(posedge CLK) disable iff (RST)
      (CPU.mem_wr && !regs_hit) |=> ROUTE.ram_wr && !ROUTE.rom_sel;
  endproperty
  a_wthru: assert property (p_wthru) else $error("write through");

  // The bus inhibit keeps every cartridge bank off.
  property p_inhibit;
    @(posedge CLK) disable iff (RST)
      EXT_ROM_INHIBIT |=> !ROUTE.rom_sel;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit");

  // The register page answers only in its window, with placement 11.
  property p_regs_win;
    @(posedge CLK) disable iff (RST)
      ROUTE.regpage_sel |-> $past(lowmap_q) == 2'h3 &&
        $past(CPU.addr[15:14]) == 2'h1;
  endproperty
  a_regs_win: assert property (p_regs_win) else $error("reg win");

  // Leaving reset: lock closed, register page off, page 0 at 0000h.
  property p_reset;
    @(posedge CLK) $fell(RST) |->
      !lock_open && lowmap_q == 2'h0 && low_page_q == 3'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");

  c_unlock: cover property (@(posedge CLK) $rose(lock_open));
  c_rmr: cover property (@(posedge CLK) rmr_wr);
  c_disk: cover property (@(posedge CLK) disk_sel && ROUTE.rom_sel);
  c_exp: cover property (@(posedge CLK) EXP_ROM_ACTIVE && !rom_live);
  c_regpage: cover property (@(posedge CLK) ROUTE.regpage_sel);

endmodule

//--- crpm_host_cpu.sv
// Host CPU model: issues one-cycle I/O and memory strobes to the mapper.
// Assumes the mapper takes a strobe on the rising edge of clk.
`timescale 1ns/10ps
module crpm_host_cpu (
  input wire logic clk,
  output crpm_pkg::crpm_cycle_s cyc
);
  // The bus starts idle so nothing is taken before the first request.
  initial begin
    cyc = '0;
  end

  // One request: raised 1 ns after an edge, held through the taking edge.
  // A released bus shows inverted values so stale data never looks valid.
  // Unlock traffic from the bench also goes out through here.
  task automatic issue(input logic [2:0] kind, input logic [15:0] a,
                       input logic [7:0] d);
    @(posedge clk);
    #1;
    cyc = {kind, a, d};
    @(posedge clk);
    #1;
    cyc = {3'h0, ~a, ~d};
  endtask
endmodule

//--- test_cartridge_rom_page_mapper.sv
// Self-checking bench for the cartridge ROM page mapper.
// Assumes the host CPU model drives the cycle bus of the mapper.
`timescale 1ns/10ps
module test_cartridge_rom_page_mapper;
  localparam logic [31:0] SEQ = 32'hA55AC33C;
  logic clk, rst, alt_sel, inhibit, exp_act, feat_open;
  logic [4:0] exp_page, cart_hi;
  logic [1:0] gate_off;
  crpm_pkg::crpm_cycle_s cyc;
  crpm_pkg::crpm_route_s route;
  int mismatches, n_compared, cycles, m_idx;
  logic [31:0] seed;
  // Reference copy of the mapper state, updated on every I/O write we issue.
  logic [7:0] m_hb;
  logic [1:0] m_map, m_gate;
  logic [2:0] m_pg;
  logic m_open;
  logic [7:0] ulk [7] = '{8'hA5, 8'h5A, 8'h00, 8'hA5, 8'h5A, 8'hC3, 8'h3C};
  logic [7:0] hv [7] = '{8'h00, 8'h07, 8'h05, 8'h7F, 8'h80, 8'h9F, 8'hFF};

  crpm_mapper #(.UNLOCK_SEQ(SEQ)) dut (.CLK(clk), .RST(rst), .CPU(cyc),
    .DISK_CODE_ALT_SEL(alt_sel), .EXT_ROM_INHIBIT(inhibit),
    .EXP_ROM_ACTIVE(exp_act), .EXP_ROM_PAGE(exp_page), .ROUTE(route),
    .CART_ADDR_HI(cart_hi), .FEATURES_OPEN(feat_open), .GATE_OFF(gate_off));
  crpm_host_cpu cpu (.clk(clk), .cyc(cyc));

  // A 100 ns clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cuts a hang short; the run needs far fewer cycles than this.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  // Physical high-bank page from the last port byte and disk-code level.
  function automatic logic [4:0] hi_page(input logic [7:0] v,
                                         input logic alt);
    if (v > 8'h7F) begin
      return v[4:0];
    end
    return (v == (alt ? 8'h07 : 8'h00)) ? 5'h03 : 5'h01;
  endfunction

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Reset values of the reference copy.
  task automatic model_reset();
    {m_hb, m_map, m_pg, m_gate, m_open} = '0;
    m_idx = 0;
  endtask

  // I/O write; the reference follows the port decode and the lock.
  task automatic io(input logic [15:0] a, input logic [7:0] d);
    cpu.issue(3'h4, a, d);
    if (a[15:8] == 8'hDF) begin
      m_hb = d;
    end else if (a[15:8] == 8'h7F && d[7:6] == 2'h2) begin
      if (d[5] && m_open) begin
        {m_map, m_pg} = d[4:0];
      end else begin
        m_gate = d[3:2];
      end
    end
    if (!m_open) begin
      m_idx = (d == SEQ[31 - 8 * m_idx -: 8]) ? m_idx + 1 :
              (d == SEQ[31:24]) ? 1 : 0;
      m_open = (m_idx == 4);
    end
  endtask

  // Memory cycle, then the routing answer one cycle later is compared.
  task automatic mem(input logic wr, input logic [15:0] a);
    logic [1:0] w;
    logic regp, hi, on;
    logic [4:0] pg;
    w = a[15:14];
    cpu.issue({1'b0, ~wr, wr}, a, seed[7:0]);
    regp = (m_map == 2'h3) && (w == 2'h1);
    hi = (w == 2'h3);
    pg = hi ? hi_page(m_hb, alt_sel) : {2'h0, m_pg};
    on = (hi ? !m_gate[1] : w == (m_map == 2'h3 ? 2'h0 : m_map) &&
         !m_gate[0]) && !inhibit && !(exp_act && exp_page == pg);
    if (wr) begin
      check("ram_wr", {7'h0, !regp}, {7'h0, route.ram_wr});
      check("regpage", {7'h0, regp}, {7'h0, route.regpage_sel});
    end else begin
      check("rom_sel", {7'h0, on}, {7'h0, route.rom_sel});
      if (on) begin
        check("cart_hi", {3'h0, pg}, {3'h0, cart_hi});
        check("rom_page", {3'h0, pg}, {3'h0, route.rom_page});
      end
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    {rst, alt_sel, inhibit, exp_act, exp_page} = 9'h100;
    {mismatches, n_compared, cycles} = '0;
    seed = 32'h000126BA;
    model_reset();
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    check("open", 8'h00, {7'h0, feat_open});
    check("gate", 8'h00, {6'h0, gate_off});
    mem(1'b0, 16'hC000);
    mem(1'b0, 16'h0123);
    // While locked, a bit 5 write lands in the gate register.
    io(16'h7F00, 8'hBF);
    check("gate", 8'h03, {6'h0, gate_off});
    mem(1'b0, 16'h0000);
    mem(1'b1, 16'h4000);
    io(16'h7F00, 8'h80);
    // Unlock with a false start; a stray byte restarts the match.
    foreach (ulk[i]) begin
      io(16'hBC00, ulk[i]);
      check("open", {7'h0, m_open}, {7'h0, feat_open});
    end
    // Every low placement code, each window read and a write at 4000h.
    for (int m = 0; m < 4; m++) begin
      io(16'h7F00, {3'h5, m[1:0], 3'h7});
      for (int k = 0; k < 4; k++) begin
        mem(1'b0, {k[1:0], 14'h0ABC});
      end
      mem(1'b1, 16'h4000);
    end
    // High-bank corners with both disk codes, then expansion priority.
    for (int k = 0; k < 14; k++) begin
      alt_sel = k[0];
      io(16'hDF00, hv[k / 2]);
      mem(1'b0, 16'hC000);
    end
    exp_act = 1'b1;
    exp_page = hi_page(m_hb, alt_sel);
    mem(1'b0, 16'hC000);
    inhibit = 1'b1;
    io(16'hDF00, 8'h07);
    mem(1'b0, 16'hC000);
    for (int i = 0; i < 300; i++) begin
      seed = xs(seed);
      alt_sel = seed[0];
      inhibit = (seed[3:1] == 3'h0);
      exp_act = (seed[6:4] == 3'h0);
      exp_page = seed[11:7];
      case (seed[13:12])
        2'h0: io({8'hDF, seed[31:24]}, seed[23:16]);
        2'h1: io({8'h7F, seed[31:24]}, {2'h2, seed[21:16]});
        default: mem(seed[12], seed[31:16]);
      endcase
    end
    // A second reset in mid-run closes the lock again.
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    model_reset();
    check("open", 8'h00, {7'h0, feat_open});
    check("gate", 8'h00, {6'h0, gate_off});
    mem(1'b0, 16'hC000);
    mem(1'b0, 16'h0000);
    give_verdict();
  end
endmodule
